// *** wrf_top.sv ***
// Watchdog timer with protected turn-off, plus sticky reset-cause flags.
// Assumes a register port with one-cycle strobes and the reset controller
// outside, which feeds cause pulses in and turns the time-out pulse into a chip reset.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module wrf_top #(
  parameter logic [21:0] TIMEOUT_BASE = wrf_pkg::TIMEOUT_BASE
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  dog_osc,
  input  wire wrf_pkg::wrf_bus_req_s bus_req,
  input  wire logic                  restart_strobe,
  input  wire wrf_pkg::wrf_cause_s   cause_in,
  output logic [7:0]                 rd_data_q,
  output logic                       dog_reset_q,
  output logic                       dog_enable_q
);

  // ==========================================================================
  // Declarations
  wrf_pkg::wrf_dog_e           state_q;
  wrf_pkg::wrf_dog_e           state_d;
  logic [wrf_pkg::CNT_W-1:0]   count_q;
  logic [wrf_pkg::CNT_W-1:0]   count_d;
  logic [wrf_pkg::CNT_W-1:0]   limit;
  logic [2:0]                  sel_q;
  logic [4:0]                  flags_q;
  logic [4:0]                  flags_d;
  logic                        osc_tick;
  logic                        unlock_open;
  logic                        unlock_arm;
  logic                        ctrl_wr;
  logic                        flags_wr;
  logic                        expire;
  logic                        enable_d;

  // ==========================================================================
  // Register port decode
  always_comb begin
    ctrl_wr  = bus_req.wr && (bus_req.addr == wrf_pkg::ADDR_CTRL);
    flags_wr = bus_req.wr && (bus_req.addr == wrf_pkg::ADDR_FLAGS);
  end

  // ==========================================================================
  // Oscillator edges
  // The oscillator is sampled rather than used as a clock, so every
  // control change and the time-out already live in the system domain.
  wrf_osc_sync u_osc_sync (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .osc_in     (dog_osc),
    .osc_tick_q (osc_tick)
  );

  // ==========================================================================
  // Turn-off unlock window
  always_comb begin
    unlock_arm = ctrl_wr && bus_req.wdata[wrf_pkg::CTRL_UNLOCK_BIT];
  end

  wrf_unlock_timer u_unlock (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .arm     (unlock_arm),
    .open_q  (unlock_open)
  );

  // ==========================================================================
  // Enable bit with turn-off protection
  always_comb begin
    enable_d = dog_enable_q;
    if (ctrl_wr) begin
      if (bus_req.wdata[wrf_pkg::CTRL_ENABLE_BIT]) begin
        enable_d = 1'b1;
      end else if (unlock_open) begin
        enable_d = 1'b0;
      end else begin
        enable_d = dog_enable_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dog_enable_q <= wrf_pkg::CTRL_RESET[wrf_pkg::CTRL_ENABLE_BIT];
    end else begin
      dog_enable_q <= enable_d;
    end
  end

  // ==========================================================================
  // Prescale select
  // Taken on every control write; a change lands mid-period and the
  // new limit applies to the count already reached.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sel_q <= wrf_pkg::CTRL_RESET[2:0];
    end else if (ctrl_wr) begin
      sel_q <= bus_req.wdata[wrf_pkg::CTRL_SEL_LSB +: 3];
    end
  end

  always_comb begin
    limit = wrf_pkg::wrf_limit(TIMEOUT_BASE, sel_q);
  end

  // ==========================================================================
  // Watchdog state machine
  always_comb begin
    expire = (state_q == wrf_pkg::DOG_RUN) && osc_tick && !restart_strobe
             && (count_q >= limit - 22'h000001);
  end

  always_comb begin
    case (state_q)
      wrf_pkg::DOG_OFF: begin
        state_d = dog_enable_q ? wrf_pkg::DOG_RUN : wrf_pkg::DOG_OFF;
      end
      wrf_pkg::DOG_RUN: begin
        if (!dog_enable_q) begin
          state_d = wrf_pkg::DOG_OFF;
        end else if (expire) begin
          state_d = wrf_pkg::DOG_FIRE;
        end else begin
          state_d = wrf_pkg::DOG_RUN;
        end
      end
      wrf_pkg::DOG_FIRE: begin
        state_d = dog_enable_q ? wrf_pkg::DOG_RUN : wrf_pkg::DOG_OFF;
      end
      default: begin
        state_d = wrf_pkg::DOG_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= wrf_pkg::DOG_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Time-out counter
  always_comb begin
    count_d = count_q;
    if (state_q != wrf_pkg::DOG_RUN) begin
      count_d = '0;
    end else if (restart_strobe) begin
      count_d = '0;
    end else if (expire) begin
      count_d = '0;
    end else if (osc_tick) begin
      count_d = count_q + 22'h000001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // ==========================================================================
  // Reset request pulse
  // One cycle wide; the reset controller starts its delay on the fall.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dog_reset_q <= 1'b0;
    end else begin
      dog_reset_q <= (state_d == wrf_pkg::DOG_FIRE);
    end
  end

  // ==========================================================================
  // Reset-cause flags
  // Not cleared by resetn: the flags must survive the very reset they
  // record. Only a power-on pulse gives them a defined value.
  always_comb begin
    flags_d = flags_q;
    if (flags_wr) begin
      flags_d = flags_q & bus_req.wdata[4:0];
    end
    if (cause_in.powerup) begin
      flags_d = wrf_pkg::FLAGS_AT_POR;
    end
    // Hardware sets win over software clears
    if (cause_in.scan_reset) begin
      flags_d[wrf_pkg::FLAG_SCAN_BIT] = 1'b1;
    end
    if (dog_reset_q) begin
      flags_d[wrf_pkg::FLAG_DOG_BIT] = 1'b1;
    end
    if (cause_in.brownout) begin
      flags_d[wrf_pkg::FLAG_BROWN_BIT] = 1'b1;
    end
    if (cause_in.pin_reset) begin
      flags_d[wrf_pkg::FLAG_PIN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    flags_q <= flags_d;
  end

  // ==========================================================================
  // Read data
  // Stands only in the cycle after the read strobe, zero otherwise.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data_q <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        wrf_pkg::ADDR_FLAGS: begin
          rd_data_q <= {3'h0, flags_q};
        end
        wrf_pkg::ADDR_CTRL: begin
          rd_data_q <= {3'h0, unlock_open, dog_enable_q, sel_q};
        end
        default: begin
          rd_data_q <= 8'h00;
        end
      endcase
    end else begin
      rd_data_q <= 8'h00;
    end
  end

endmodule : wrf_top

// *** wrf_pkg.sv ***
// Package for the watchdog and reset-cause flag block.
// Assumes a 40 MHz system clock and a free-running 1 MHz watchdog oscillator input.
package wrf_pkg;

  // ==========================================================================
  // Clocking
  localparam int unsigned SYS_CLK_HZ    = 40_000_000;
  localparam int unsigned DOG_OSC_HZ    = 1_000_000;
  localparam int unsigned UNLOCK_CYCLES = 4;
  localparam logic [2:0]  UNLOCK_LAST   = 3'(UNLOCK_CYCLES - 1);

  // ==========================================================================
  // Register map (byte addresses on the register port)
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_CTRL  = 4'h1;

  // ==========================================================================
  // Control register fields
  localparam int unsigned CTRL_UNLOCK_BIT = 4;
  localparam int unsigned CTRL_ENABLE_BIT = 3;
  localparam int unsigned CTRL_SEL_LSB    = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  // ==========================================================================
  // Reset-cause flag fields
  localparam int unsigned FLAG_SCAN_BIT  = 4;
  localparam int unsigned FLAG_DOG_BIT   = 3;
  localparam int unsigned FLAG_BROWN_BIT = 2;
  localparam int unsigned FLAG_PIN_BIT   = 1;
  localparam int unsigned FLAG_POWER_BIT = 0;
  localparam logic [4:0]  FLAGS_AT_POR   = 5'h01;

  // ==========================================================================
  // Time-out counter
  localparam int unsigned CNT_W          = 22;
  localparam logic [CNT_W-1:0] TIMEOUT_BASE = 22'h004000;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    DOG_OFF  = 3'b001,
    DOG_RUN  = 3'b010,
    DOG_FIRE = 3'b100
  } wrf_dog_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wrf_bus_req_s;

  typedef struct packed {
    logic scan_reset;
    logic brownout;
    logic pin_reset;
    logic powerup;
  } wrf_cause_s;

  // Oscillator cycles in one period for a prescale code
  function automatic logic [CNT_W-1:0] wrf_limit(input logic [CNT_W-1:0] base,
                                                 input logic [2:0]       sel);
    wrf_limit = base << sel;
  endfunction : wrf_limit

endpackage : wrf_pkg

// *** wrf_osc_sync.sv ***
// Samples the watchdog oscillator and gives a one-cycle tick per rising edge.
// Assumes the oscillator runs well below half the system clock rate.
`timescale 1ns/100ps
module wrf_osc_sync (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic osc_in,
  output logic      osc_tick_q
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // ==========================================================================
  // Two-flop synchroniser, then edge detect on the settled stage
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= osc_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      osc_tick_q <= 1'b0;
    end else begin
      osc_tick_q <= sync_q & ~last_q;
    end
  end

endmodule : wrf_osc_sync

// *** wrf_unlock_timer.sv ***
// Holds the turn-off unlock window open for a fixed count of system cycles.
// Assumes arm is a one-cycle pulse from a register write.
`timescale 1ns/100ps
module wrf_unlock_timer (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic arm,
  output logic      open_q
);

  logic [2:0] left_q;

  // ==========================================================================
  // Window counter; re-arming restarts the full window
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      open_q <= 1'b0;
      left_q <= 3'h0;
    end else if (arm) begin
      open_q <= 1'b1;
      left_q <= wrf_pkg::UNLOCK_LAST;
    end else if (open_q) begin
      if (left_q == 3'h0) begin
        open_q <= 1'b0;
      end else begin
        left_q <= left_q - 3'h1;
      end
    end
  end

endmodule : wrf_unlock_timer

// *** wrf_monitor.sv ***
// Checker for the watchdog and reset-flag block.
// Assumes it is bound to wrf_top and sees only its ports.
`timescale 1ns/100ps
module wrf_monitor #(
  parameter logic [21:0] TIMEOUT_BASE = wrf_pkg::TIMEOUT_BASE
) (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  dog_osc,
  input wire wrf_pkg::wrf_bus_req_s bus_req,
  input wire logic                  restart_strobe,
  input wire wrf_pkg::wrf_cause_s   cause_in,
  input wire logic [7:0]            rd_data_q,
  input wire logic                  dog_reset_q,
  input wire logic                  dog_enable_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ========================================
  // Helpers
  logic        wr_c;
  logic        rd_c;
  logic        win;
  logic [2:0]  win_q;
  logic [2:0]  sel_q;
  logic        osc_q;
  logic [22:0] ticks_q;
  logic [22:0] lim;
  assign wr_c = bus_req.wr && bus_req.addr == wrf_pkg::ADDR_CTRL;
  assign rd_c = bus_req.rd && bus_req.addr == wrf_pkg::ADDR_CTRL;
  assign win  = win_q != 3'h0;
  assign lim  = 23'(TIMEOUT_BASE << sel_q);
  always_ff @(posedge sys_clk) begin
    if (!resetn) win_q <= 3'h0;
    else if (wr_c && bus_req.wdata[4]) win_q <= 3'h4;
    else if (win) win_q <= win_q - 3'h1;
    if (!resetn) sel_q <= 3'h0;
    else if (wr_c) sel_q <= bus_req.wdata[2:0];
  end
  // Oscillator rises may land one tick either side of a clear
  always_ff @(posedge sys_clk) begin
    osc_q <= dog_osc;
    if (!resetn || !dog_enable_q || restart_strobe || dog_reset_q) ticks_q <= 23'h0;
    else if (dog_osc && !osc_q) ticks_q <= ticks_q + 23'h1;
  end
  // ========================================
  // Assertions
  AST_RSV: assert property (rd_c |=> rd_data_q[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  AST_UNLOCK: assert property (rd_c |=> rd_data_q[4] == $past(win))
    else $error("unlock bit disagrees with four cycle window");
  AST_EN_SET: assert property (wr_c && bus_req.wdata[3] |=> dog_enable_q)
    else $error("enable write of one ignored");
  AST_EN_OFF: assert property (wr_c && !bus_req.wdata[3] && win |=> !dog_enable_q)
    else $error("unlocked disable ignored");
  AST_EN_HOLD: assert property (wr_c && bus_req.wdata[4:3] == 2'b00 && !win && dog_enable_q |=> dog_enable_q)
    else $error("disable taken without unlock");
  AST_PULSE: assert property (dog_reset_q |=> !dog_reset_q)
    else $error("reset pulse longer than one cycle");
  AST_QUIET: assert property (!dog_enable_q [*4] |-> !dog_reset_q)
    else $error("time-out while disabled");
  AST_RESTART: assert property (restart_strobe |=> !dog_reset_q [*8])
    else $error("time-out right after restart");
  AST_PERIOD: assert property (dog_reset_q |-> ticks_q + 23'h1 >= lim && ticks_q <= lim)
    else $error("time-out period wrong");
  AST_FIRES: assert property (ticks_q <= lim)
    else $error("no time-out after full period");
  COV_FIRE: cover property (dog_reset_q);
  COV_OFF: cover property (wr_c && !bus_req.wdata[3] && win && dog_enable_q);
  COV_RST: cover property (restart_strobe && dog_enable_q);
endmodule : wrf_monitor

bind wrf_top wrf_monitor #(.TIMEOUT_BASE(TIMEOUT_BASE)) u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .dog_osc(dog_osc), .bus_req(bus_req),
  .restart_strobe(restart_strobe), .cause_in(cause_in), .rd_data_q(rd_data_q),
  .dog_reset_q(dog_reset_q), .dog_enable_q(dog_enable_q));

// *** watchdog_and_reset_flags_test.sv ***
// Self-checking bench for the watchdog and reset-flag block.
// Assumes wrf_top and its checker are compiled before it.
`timescale 1ns/100ps
module watchdog_and_reset_flags_test;
  logic                  sys_clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  dog_osc = 1'b0;
  wrf_pkg::wrf_bus_req_s bus_req = '0;
  logic                  restart_strobe = 1'b0;
  wrf_pkg::wrf_cause_s   cause_in = 4'h1;
  logic [7:0]            rd_data_q;
  logic                  dog_reset_q;
  logic                  dog_enable_q;
  logic [5:0]            oc_q = 6'h00;
  logic [7:0]            v;
  int                    mismatches = 0;
  int                    n_checks = 0;
  int                    pulses = 0;
  int                    n;
  logic [15:0]           rows [8] = '{16'h0004, 16'h0008, 16'h0010, 16'h0020,
                                      16'h0040, 16'h0080, 16'h0100, 16'h0200};
  wrf_top #(.TIMEOUT_BASE(22'h000004)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .dog_osc(dog_osc), .bus_req(bus_req),
    .restart_strobe(restart_strobe), .cause_in(cause_in), .rd_data_q(rd_data_q),
    .dog_reset_q(dog_reset_q), .dog_enable_q(dog_enable_q));
  initial forever #12.5 sys_clk = ~sys_clk;
  // Oscillator built in the clock domain, 40 cycles a period
  always @(posedge sys_clk) begin
    oc_q <= (oc_q == 6'h27) ? 6'h00 : oc_q + 6'h01;
    if (oc_q == 6'h13 || oc_q == 6'h27) dog_osc <= ~dog_osc;
    if (dog_reset_q === 1'b1) pulses++;
  end
  // ========================================
  // Tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 d = rd_data_q;
    @(posedge sys_clk);
  endtask : rd
  task automatic pz(input logic [3:0] c);
    cause_in <= c;
    @(posedge sys_clk);
    cause_in <= 4'h0;
    @(posedge sys_clk);
  endtask : pz
  task automatic done(input string s);
    $display("%s done, checks %0d", s, n_checks);
  endtask : done
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // ========================================
  // Watchdog of the run
  initial begin
    repeat (80000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
  // ========================================
  // Sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    cause_in <= 4'h0;
    @(posedge sys_clk);
    rd(wrf_pkg::ADDR_CTRL, v);
    chk(16'(v), 16'h0000);
    rd(wrf_pkg::ADDR_FLAGS, v);
    chk(16'(v), 16'h0001);
    wr(wrf_pkg::ADDR_FLAGS, 8'h00);
    // Writes land mid-period so no rise straddles the enable
    for (int s = 0; s < 8; s++) begin
      @(posedge sys_clk iff (oc_q == 6'h0A));
      wr(wrf_pkg::ADDR_CTRL, {5'h01, 3'(s)});
      n = 0;
      for (int k = 0; k < 25000 && dog_reset_q !== 1'b1; k++) begin
        @(posedge sys_clk);
        if (oc_q == 6'h13) n++;
      end
      chk(16'(n), rows[s]);
      repeat (2) @(posedge sys_clk);
      rd(wrf_pkg::ADDR_FLAGS, v);
      chk(16'(v), 16'h0008);
      wr(wrf_pkg::ADDR_FLAGS, 8'h00);
      wr(wrf_pkg::ADDR_CTRL, 8'h18);
      wr(wrf_pkg::ADDR_CTRL, 8'h00);
      chk(16'(dog_enable_q), 16'h0000);
    end
    done("periods");
    pz(4'hE);
    rd(wrf_pkg::ADDR_FLAGS, v);
    chk(16'(v), 16'h0016);
    pz(4'h1);
    rd(wrf_pkg::ADDR_FLAGS, v);
    chk(16'(v), 16'h0001);
    wr(wrf_pkg::ADDR_FLAGS, 8'h00);
    rd(wrf_pkg::ADDR_FLAGS, v);
    chk(16'(v), 16'h0000);
    done("flags");
    wr(wrf_pkg::ADDR_CTRL, 8'hFF);
    rd(wrf_pkg::ADDR_CTRL, v);
    chk(16'(v), 16'h001F);
    repeat (4) @(posedge sys_clk);
    rd(wrf_pkg::ADDR_CTRL, v);
    chk(16'(v), 16'h000F);
    wr(wrf_pkg::ADDR_CTRL, 8'h00);
    chk(16'(dog_enable_q), 16'h0001);
    wr(wrf_pkg::ADDR_CTRL, 8'h18);
    wr(wrf_pkg::ADDR_CTRL, 8'h00);
    chk(16'(dog_enable_q), 16'h0000);
    wr(4'h5, 8'hFF);
    rd(wrf_pkg::ADDR_CTRL, v);
    chk(16'(v), 16'h0000);
    done("control");
    n = pulses;
    wr(wrf_pkg::ADDR_CTRL, 8'h08);
    repeat (8) begin
      repeat (100) @(posedge sys_clk);
      restart_strobe <= 1'b1;
      @(posedge sys_clk);
      restart_strobe <= 1'b0;
    end
    chk(16'(pulses - n), 16'h0000);
    repeat (200) @(posedge sys_clk);
    chk(16'(pulses - n), 16'h0001);
    repeat (60) @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(16'(dog_enable_q), 16'h0000);
    n = pulses;
    repeat (300) @(posedge sys_clk);
    chk(16'(pulses - n), 16'h0000);
    rd(wrf_pkg::ADDR_FLAGS, v);
    chk(16'(v), 16'h0008);
    done("restart and reset");
    give_verdict();
  end
endmodule : watchdog_and_reset_flags_test
